// >>> hw/pis_top.sv
// interrupt and power-save control of the transceiver
`timescale 1ns/10ps

// Operation
// - all interrupt sources disabled after reset
// - per-source enable bits in two registers
// - enabled interrupt drives pin without clock
// - status shows every pending interrupt
// - reading a status register clears the pending interrupts of that register
// - power-down by pin low or control bit
// - management access stays alive in power-down
// - bit 14 enables, bits 13:12 select mode
// - select 01 forces ieee power-down
// - select 10 enters active energy saving
// - select 11 enters passive energy saving
// - clearing bits resumes prior operating state
// - three modes, ieee power-down lowest
// - pin is power-down input unless enabled
// - register holds global enable and polarity
module pis_top
   import pis_pkg::*;
#(
   parameter int SRC_PER_REG = MS_SOURCES
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // management register port
   input wire pis_reg_req_t reg_req_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // interrupt conditions from the transceiver
   input wire logic [2*SRC_PER_REG-1:0] irq_src_i,
   // shared interrupt / power-down pin
   input wire logic irq_powerdown_pin_i,
   output logic irq_powerdown_pin_o,
   output logic irq_powerdown_pin_oe_o,
   // power controls
   output pis_power_t power_o,
   output pis_power_state_t power_state_o
);

   generate
      if (SRC_PER_REG < 1 || SRC_PER_REG > MS_SOURCES)
         $error("pis_top: SRC_PER_REG out of range");
   endgenerate

   localparam int N = SRC_PER_REG;

   logic [15:0] basic_control;
   logic [15:0] power_save_control;
   logic [N-1:0] enable_one;
   logic [N-1:0] enable_two;
   logic [N-1:0] pending_one;
   logic [N-1:0] pending_two;
   logic pin_level;
   logic wr_basic;
   logic wr_psc;
   logic wr_one;
   logic wr_two;
   logic rd_one;
   logic rd_two;
   logic int_oe;
   logic int_en;
   logic int_pol;
   logic ps_en;
   logic [1:0] ps_sel;
   logic irq_active;
   logic pd_request;
   pis_power_state_t power_state;
   pis_power_state_t next_power_state;
   logic [15:0] next_rdata;

   // register decode
   assign wr_basic = reg_req_i.wr && reg_req_i.addr == ADDR_BASIC_CONTROL;
   assign wr_psc = reg_req_i.wr && reg_req_i.addr == ADDR_POWER_SAVE_CONTROL;
   assign wr_one = reg_req_i.wr && reg_req_i.addr == ADDR_MASK_STATUS_ONE;
   assign wr_two = reg_req_i.wr && reg_req_i.addr == ADDR_MASK_STATUS_TWO;
   assign rd_one = reg_req_i.rd && reg_req_i.addr == ADDR_MASK_STATUS_ONE;
   assign rd_two = reg_req_i.rd && reg_req_i.addr == ADDR_MASK_STATUS_TWO;

   assign int_oe = power_save_control[PSC_INT_OE_BIT];
   assign int_en = power_save_control[PSC_INT_EN_BIT];
   assign int_pol = power_save_control[PSC_INT_POL_BIT];
   assign ps_en = power_save_control[PSC_PS_EN_BIT];
   assign ps_sel = power_save_control[PSC_MODE_MSB:PSC_MODE_LSB];

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         basic_control <= BASIC_CONTROL_RST;
      else if (wr_basic)
         basic_control <= reg_req_i.wdata;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         power_save_control <= POWER_SAVE_CONTROL_RST;
      else if (wr_psc)
         power_save_control <= reg_req_i.wdata;
   end

   pis_irq_bank #(
      .N(N)
   ) u_bank_one (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .src_i(irq_src_i[N-1:0]),
      .wr_i(wr_one),
      .wdata_i(reg_req_i.wdata[MS_ENABLE_LSB +: N]),
      .rd_i(rd_one),
      .enable_o(enable_one),
      .pending_o(pending_one)
   );

   pis_irq_bank #(
      .N(N)
   ) u_bank_two (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .src_i(irq_src_i[2*N-1:N]),
      .wr_i(wr_two),
      .wdata_i(reg_req_i.wdata[MS_ENABLE_LSB +: N]),
      .rd_i(rd_two),
      .enable_o(enable_two),
      .pending_o(pending_two)
   );

   pis_pin_sync u_pin_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(irq_powerdown_pin_i),
      .level_o(pin_level)
   );

   // pending or a live enabled condition, no clock in the path
   assign irq_active = int_en &&
      (|pending_one || |pending_two ||
       |(irq_src_i[N-1:0] & enable_one) ||
       |(irq_src_i[2*N-1:N] & enable_two));

   // deliberately combinational so the pin falls before the next edge
   // driven only when the output enable bit is set
   assign irq_powerdown_pin_oe_o = int_oe;
   // polarity 0 gives the default active-low level
   assign irq_powerdown_pin_o = int_pol ? irq_active : ~irq_active;

   // pin low, control bit, or select 01
   // pin level ignored while it is our output
   // select 01 acts like the control bit
   assign pd_request = (!int_oe && !pin_level) ||
      basic_control[BC_POWER_DOWN_BIT] ||
      (ps_en && ps_sel == PS_SEL_IEEE_PD);

   // ieee power-down outranks both energy-saving modes
   always_comb
   begin
      next_power_state = PS_ACTIVE;
      if (pd_request)
         next_power_state = PS_IEEE_PD;
      else if (ps_en)
      begin
         case (ps_sel)
            PS_SEL_ACTIVE_ES: next_power_state = PS_ACTIVE_ES;
            PS_SEL_PASSIVE_ES: next_power_state = PS_PASSIVE_ES;
            default: next_power_state = PS_ACTIVE;
         endcase
      end
   end

   // leaving a mode returns to the selected energy-saving mode, else active; core state is frozen
   // never reset, so it resumes where it stopped
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         power_state <= PS_ACTIVE;
      else
         power_state <= next_power_state;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         power_o <= '0;
      else
      begin
         power_o.core_off <= next_power_state == PS_IEEE_PD;
         power_o.active_es <= next_power_state == PS_ACTIVE_ES;
         power_o.passive_es <= next_power_state == PS_PASSIVE_ES;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         power_state_o <= PS_ACTIVE;
      else
         power_state_o <= next_power_state;
   end

   // pending bits shown in the upper half
   always_comb
   begin
      next_rdata = READ_ZERO;
      case (reg_req_i.addr)
         ADDR_BASIC_CONTROL: next_rdata = basic_control;
         ADDR_POWER_SAVE_CONTROL: next_rdata = power_save_control;
         ADDR_MASK_STATUS_ONE:
         begin
            next_rdata[MS_ENABLE_LSB +: N] = enable_one;
            next_rdata[MS_PENDING_LSB +: N] = pending_one;
         end
         ADDR_MASK_STATUS_TWO:
         begin
            next_rdata[MS_ENABLE_LSB +: N] = enable_two;
            next_rdata[MS_PENDING_LSB +: N] = pending_two;
         end
         default: next_rdata = READ_ZERO;
      endcase
   end

   // register port never gated by power state
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= READ_ZERO;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_req_i.rd;
         if (reg_req_i.rd)
            reg_rdata_o <= next_rdata;
      end
   end

   // checks

   reset_mask_a:
   assert property (@(posedge core_clk_i)
      $past(rst_i) && !rst_i |-> enable_one == '0 && enable_two == '0)
   else $error("enables not cleared by reset");

   pin_assert_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      int_oe && int_en && |(irq_src_i[N-1:0] & enable_one)
      |-> irq_powerdown_pin_oe_o && irq_powerdown_pin_o == int_pol)
   else $error("pin not asserted for enabled interrupt");

   pend_set_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      |(irq_src_i[2*N-1:N] & enable_two) |=> |pending_two)
   else $error("enabled event did not set pending");

   read_clear_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      rd_one && !(|(irq_src_i[N-1:0] & enable_one))
      |=> pending_one == '0)
   else $error("status read did not clear pending");

   read_data_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      rd_one ##1 1'b1
      |-> reg_rdata_o[MS_PENDING_LSB +: N] == $past(pending_one))
   else $error("read data lost a pending bit");

   ctrl_pd_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      basic_control[BC_POWER_DOWN_BIT] |=> power_state == PS_IEEE_PD
      && power_o.core_off)
   else $error("control bit did not enter power-down");

   pin_pd_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      int_oe && !basic_control[BC_POWER_DOWN_BIT] && !ps_en
      |=> power_state == PS_ACTIVE)
   else $error("output pin level taken as power-down");

   sel_pd_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      ps_en && ps_sel == PS_SEL_IEEE_PD |=> power_state == PS_IEEE_PD)
   else $error("select 01 did not enter power-down");

   active_es_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      !pd_request && ps_en && ps_sel == PS_SEL_ACTIVE_ES
      |=> power_state == PS_ACTIVE_ES && power_o.active_es)
   else $error("active energy saving not entered");

   passive_es_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      !pd_request && ps_en && ps_sel == PS_SEL_PASSIVE_ES
      |=> power_state == PS_PASSIVE_ES && power_o.passive_es)
   else $error("passive energy saving not entered");

   resume_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      power_state == PS_IEEE_PD && !pd_request && !ps_en
      |=> power_state == PS_ACTIVE && !power_o.core_off)
   else $error("did not resume after power-save cleared");

   mgmt_alive_a:
   assert property (@(posedge core_clk_i) disable iff (rst_i)
      power_state == PS_IEEE_PD && reg_req_i.rd |=> reg_rvalid_o)
   else $error("register read lost in power-down");

endmodule

// >>> hw/pis_pkg.sv
// shared constants and types for the phy interrupt and power-save block
package pis_pkg;

   // management register addresses
   localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_POWER_SAVE_CONTROL = 5'h11;
   localparam logic [4:0] ADDR_MASK_STATUS_ONE = 5'h12;
   localparam logic [4:0] ADDR_MASK_STATUS_TWO = 5'h13;

   // basic_control fields
   localparam int BC_POWER_DOWN_BIT = 11;

   // power_save_control fields
   localparam int PSC_INT_OE_BIT = 0;
   localparam int PSC_INT_EN_BIT = 1;
   localparam int PSC_INT_POL_BIT = 3;
   localparam int PSC_MODE_LSB = 12;
   localparam int PSC_MODE_MSB = 13;
   localparam int PSC_PS_EN_BIT = 14;

   // mask/status layout: enables in the low half, pending in the high half
   localparam int MS_ENABLE_LSB = 0;
   localparam int MS_PENDING_LSB = 8;
   localparam int MS_SOURCES = 8;

   // power-save select encodings
   localparam logic [1:0] PS_SEL_NONE = 2'h0;
   localparam logic [1:0] PS_SEL_IEEE_PD = 2'h1;
   localparam logic [1:0] PS_SEL_ACTIVE_ES = 2'h2;
   localparam logic [1:0] PS_SEL_PASSIVE_ES = 2'h3;

   // reset values
   localparam logic [15:0] BASIC_CONTROL_RST = 16'h0000;
   localparam logic [15:0] POWER_SAVE_CONTROL_RST = 16'h0000;
   localparam logic [15:0] READ_ZERO = 16'h0000;

   // idle level of the shared pin (weak pull-up)
   localparam logic PIN_IDLE = 1'b1;

   // power states, gray coded along act -> es -> es -> pd
   typedef enum logic [1:0] {
      PS_ACTIVE = 2'b00,
      PS_ACTIVE_ES = 2'b01,
      PS_PASSIVE_ES = 2'b11,
      PS_IEEE_PD = 2'b10
   } pis_power_state_t;

   // one management access per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pis_reg_req_t;

   // power controls to the rest of the transceiver
   typedef struct packed {
      logic core_off;
      logic active_es;
      logic passive_es;
   } pis_power_t;

endpackage

// >>> hw/pis_pin_sync.sv
// three-stage synchroniser with agreement filter for the shared pin
`timescale 1ns/10ps
module pis_pin_sync
   import pis_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // pin level in, filtered level out
   input wire logic pin_i,
   output logic level_o
);

   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1 <= PIN_IDLE;
         stage2 <= PIN_IDLE;
         stage3 <= PIN_IDLE;
      end
      else
      begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a change only counts once the last two stages agree
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         level_o <= PIN_IDLE;
      else if (stage2 == stage3)
         level_o <= stage3;
   end

endmodule

// >>> hw/pis_irq_bank.sv
// one interrupt mask/status register: enables and sticky pending bits
`timescale 1ns/10ps
module pis_irq_bank
   import pis_pkg::*;
#(
   parameter int N = MS_SOURCES
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // interrupt conditions
   input wire logic [N-1:0] src_i,
   // register access
   input wire logic wr_i,
   input wire logic [N-1:0] wdata_i,
   input wire logic rd_i,
   // state
   output logic [N-1:0] enable_o,
   output logic [N-1:0] pending_o
);

   generate
      if (N < 1 || N > MS_SOURCES)
         $error("pis_irq_bank: N out of range");
   endgenerate

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
               enable_o[i] <= 1'b0;
            else if (wr_i)
               enable_o[i] <= wdata_i[i];
         end

         // read clears, a new event wins
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
               pending_o[i] <= 1'b0;
            else if (src_i[i] && enable_o[i])
               pending_o[i] <= 1'b1;
            else if (rd_i)
               pending_o[i] <= 1'b0;
         end
      end
   endgenerate

endmodule

// >>> test/pis_pin_partner.sv
// external party on the shared pin: weak pull-up and open-drain pull
`timescale 1ns/10ps
module pis_pin_partner
(
   // device side of the pin
   input wire logic dev_pin_i,
   input wire logic dev_oe_i,
   // external power-down request
   input wire logic pull_low_i,
   // resolved pin level
   output logic wire_o
);
   // pin driven by the device, else pulled low on request, else pulled up
   // the pull is withheld while the device drives, so no contention
   always_comb
   begin
      if (dev_oe_i)
         wire_o = dev_pin_i;
      else if (pull_low_i)
         wire_o = 1'b0;
      else
         wire_o = 1'b1;
   end
endmodule

// >>> test/pis_top_tb_top.sv
// self-checking bench for the interrupt and power-save block
`timescale 1ns/10ps
module pis_top_tb_top
   import pis_pkg::*;
;
   logic core_clk;
   logic rst;
   pis_reg_req_t req;
   logic [15:0] rdata;
   logic rvalid;
   logic [15:0] src;
   logic pin_o;
   logic pin_oe;
   logic pin_wire;
   logic ext_low;
   pis_power_t pwr;
   pis_power_state_t pstate;
   int err_total;
   int total_checks;
   logic [4:0] rst_addr [5] = '{5'h00, 5'h11, 5'h12, 5'h13, 5'h05};
   pis_power_state_t mode_st [4] =
      '{PS_ACTIVE, PS_IEEE_PD, PS_ACTIVE_ES, PS_PASSIVE_ES};
   logic [2:0] mode_pw [4] = '{3'h0, 3'h4, 3'h2, 3'h1};

   always #10 core_clk = ~core_clk;

   pis_top #(.SRC_PER_REG(8)) i_pis_top (
      .core_clk_i(core_clk),
      .rst_i(rst),
      .reg_req_i(req),
      .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid),
      .irq_src_i(src),
      .irq_powerdown_pin_i(pin_wire),
      .irq_powerdown_pin_o(pin_o),
      .irq_powerdown_pin_oe_o(pin_oe),
      .power_o(pwr),
      .power_state_o(pstate)
   );

   pis_pin_partner i_pis_pin_partner (
      .dev_pin_i(pin_o),
      .dev_oe_i(pin_oe),
      .pull_low_i(ext_low),
      .wire_o(pin_wire)
   );

   task automatic conclude();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // entered and left at a falling edge; one idle cycle keeps strobes apart
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge core_clk);
      req.wr = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge core_clk);
      req.rd = 1'b0;
      chk(16'(rvalid), 16'h0001);
      chk(rdata, exp);
      @(negedge core_clk);
   endtask

   // state follows its request a cycle or two later; the pin path is slower
   task automatic wait_state(input pis_power_state_t s, input logic [2:0] p);
      int n;
      n = 0;
      repeat (2) @(negedge core_clk);
      while (pstate !== s && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      total_checks++;
      if (pstate !== s || pwr !== p)
      begin
         err_total++;
         $display("[ERR] t=%0t state=%h exp=%h power=%h exp=%h",
            $time, pstate, s, pwr, p);
         conclude();
      end
   endtask

   initial
   begin
      core_clk = 1'b0;
      rst = 1'b1;
      req = '0;
      src = 16'h0000;
      ext_low = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      foreach (rst_addr[i])
         reg_rd(rst_addr[i], 16'h0000);
      chk(16'(pin_oe), 16'h0000);
      src = 16'hffff;
      @(negedge core_clk);
      src = 16'h0000;
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h0000);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h0000);
      reg_wr(ADDR_MASK_STATUS_ONE, 16'hffff);
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h00ff);
      reg_wr(ADDR_MASK_STATUS_TWO, 16'h5aa5);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h00a5);
      reg_wr(ADDR_MASK_STATUS_ONE, 16'h0001);
      reg_wr(ADDR_MASK_STATUS_TWO, 16'h0004);
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h0003);
      chk(16'(pin_oe), 16'h0001);
      chk(16'(pin_wire), 16'h0001);
      // bit 1 is not enabled and must neither latch nor assert
      src = 16'h0403;
      #1;
      chk(16'(pin_wire), 16'h0000);
      @(negedge core_clk);
      src = 16'h0000;
      repeat (4) @(negedge core_clk);
      wait_state(PS_ACTIVE, 3'h0);
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h0101);
      chk(16'(pin_wire), 16'h0000);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h0404);
      chk(16'(pin_wire), 16'h0001);
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h0001);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h0004);
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h000b);
      chk(16'(pin_wire), 16'h0000);
      src = 16'h0001;
      #1;
      chk(16'(pin_wire), 16'h0001);
      @(negedge core_clk);
      src = 16'h0000;
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h0101);
      chk(16'(pin_wire), 16'h0000);
      // global enable off: pin stays idle yet the event is still recorded
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h0001);
      src = 16'h0001;
      @(negedge core_clk);
      src = 16'h0000;
      @(negedge core_clk);
      chk(16'(pin_wire), 16'h0001);
      reg_rd(ADDR_MASK_STATUS_ONE, 16'h0101);
      reg_wr(ADDR_BASIC_CONTROL, 16'h0800);
      wait_state(PS_IEEE_PD, 3'h4);
      reg_rd(ADDR_BASIC_CONTROL, 16'h0800);
      reg_wr(ADDR_MASK_STATUS_TWO, 16'h00ff);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h00ff);
      reg_wr(ADDR_BASIC_CONTROL, 16'h0000);
      wait_state(PS_ACTIVE, 3'h0);
      for (int s = 0; s < 4; s++)
      begin
         reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h4000 | 16'(s << 12));
         wait_state(mode_st[s], mode_pw[s]);
         reg_wr(ADDR_POWER_SAVE_CONTROL, 16'(s << 12));
         wait_state(PS_ACTIVE, 3'h0);
      end
      // ieee power-down outranks an energy-saving mode, which then resumes
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h6000);
      reg_wr(ADDR_BASIC_CONTROL, 16'h0800);
      wait_state(PS_IEEE_PD, 3'h4);
      reg_wr(ADDR_BASIC_CONTROL, 16'h0000);
      wait_state(PS_ACTIVE_ES, 3'h2);
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h0000);
      wait_state(PS_ACTIVE, 3'h0);
      ext_low = 1'b1;
      wait_state(PS_IEEE_PD, 3'h4);
      ext_low = 1'b0;
      wait_state(PS_ACTIVE, 3'h0);
      // a second reset in mid-run must restore the disabled state
      reg_wr(ADDR_POWER_SAVE_CONTROL, 16'h0003);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      reg_rd(ADDR_POWER_SAVE_CONTROL, 16'h0000);
      reg_rd(ADDR_MASK_STATUS_TWO, 16'h0000);
      chk(16'(pin_oe), 16'h0000);
      conclude();
   end
endmodule
